/* design/wds_consts.svh */
`ifndef WDS_CONSTS_SVH
`define WDS_CONSTS_SVH
// register map (word index of the plain register port)
`define WDS_ADDR_PRESCALE 4'h0
`define WDS_ADDR_STATUS 4'h1
`define WDS_ADDR_ID0 4'h4
// prescale_config fields and reset value
`define WDS_PRESCALE_RESET 6'h3F
`define WDS_PSA_BIT 3
`define WDS_RATIO_MSB 2
// status read layout
`define WDS_TO_BIT 4
`define WDS_PD_BIT 3
// identification locations
`define WDS_ID_COUNT 4
`define WDS_ID_WIDTH 12
// timing: 18 ms nominal at 10 MHz
`define WDS_TIMEOUT_MS 18
`define WDS_CLK_HZ 10000000
`define WDS_TIMEOUT_CYC ((`WDS_TIMEOUT_MS * `WDS_CLK_HZ) / 1000)
`endif

/* design/wds_pkg.sv */
package wds_pkg;
  typedef enum logic [1:0] {
    WDS_RUN = 2'b00,
    WDS_SLEEP = 2'b01,
    WDS_HOLD = 2'b10
  } wds_state_e;
  typedef logic [5:0] wds_prescale_t;
endpackage

/* design/wds_watchdog.sv */
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wds_consts.svh"
// Overview of operation
// - watchdog ticks from own oscillator, also asleep
// - timeout gives full device reset always
// - watchdog reset clears timeout flag
// - fuse at zero disables watchdog entirely
// - nominal 18 ms period without prescaler
// - prescaler up to 1:128 when assigned
// - kick clears counter and assigned prescaler
// - sleep clears counter and assigned prescaler
// - six-bit prescale config, ones on reset
// - flag pair encodes last reset cause
// - only four events change the flags
// - pin reset leaves flags unchanged
// - timeout and sleep ignore flag values
// - sleep stops oscillator, pins hold state
// - watchdog reset never drives reset pin
// - wake only by pin or timeout, resets
// - counter cleared on every wake-up
// - programmer reads memory while unprotected
// - four id words, program mode only
// - timeout also starts reset hold timer
module wds_watchdog
  import wds_pkg::*;
#(
  parameter int TIMEOUT_CYC = `WDS_TIMEOUT_CYC,
  parameter int HOLD_CYC = `WDS_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic wdt_osc_tick_in,
  input wire logic master_clear_n_in,
  input wire logic watchdog_enable_fuse_in,
  input wire logic code_protect_n_in,
  input wire logic program_mode_in,
  input wire logic kick_instruction_in,
  input wire logic sleep_instruction_in,
  input wire logic [3:0] addr_in,
  input wire logic [11:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [11:0] rdata_out,
  output logic cpu_reset_out,
  output logic osc_driver_en_out,
  output logic pin_hold_out,
  output logic master_clear_oe_out,
  output logic verify_read_en_out,
  output logic timeout_flag_out,
  output logic powerdown_flag_out
);
  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] tick_sync;
  logic [1:0] master_clear_pin_sync;
  // fuse and mode pins are static in use but still arrive as pins
  logic [1:0] fuse_sync;
  logic [1:0] prog_sync;
  logic [1:0] unprot_sync;
  logic tick_seen;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_sync <= 2'h0;
      master_clear_pin_sync <= 2'h3;
      fuse_sync <= 2'h0;
      prog_sync <= 2'h0;
      unprot_sync <= 2'h0;
      tick_seen <= 1'b0;
    end else begin
      tick_sync <= {tick_sync[0], wdt_osc_tick_in};
      master_clear_pin_sync <= {master_clear_pin_sync[0], master_clear_n_in};
      fuse_sync <= {fuse_sync[0], watchdog_enable_fuse_in};
      prog_sync <= {prog_sync[0], program_mode_in};
      unprot_sync <= {unprot_sync[0], code_protect_n_in};
      tick_seen <= tick_sync[1];
    end
  end
  // one pulse per rising edge of the slow oscillator tick
  wire osc_edge = tick_sync[1] & ~tick_seen;
  wire master_clear_pin_low = ~master_clear_pin_sync[1];
  wire fuse_on = fuse_sync[1];
  wire prog_mode = prog_sync[1];
  wire unprotected = unprot_sync[1];

  // ---------------------------------------------------------------
  // prescale config and state
  // ---------------------------------------------------------------
  wds_prescale_t prescale_config;
  wds_state_e state;
  wds_state_e next_state;
  logic [31:0] wdt_count;
  logic [6:0] post_count;
  logic [31:0] hold_count;
  logic timeout_flag;
  logic powerdown_flag;
  logic expire;
  logic [`WDS_ID_WIDTH-1:0] id_mem [`WDS_ID_COUNT];

  function automatic logic [6:0] ratio_mask(input logic [2:0] r);
    ratio_mask = 7'(({7'h0, 1'b1} << r) - 8'h1);
  endfunction

  // read-side image of the two reset cause flags
  function automatic logic [11:0] status_word(input logic to_bit, input logic pd_bit);
    logic [11:0] word;
    word = 12'h000;
    word[`WDS_TO_BIT] = to_bit;
    word[`WDS_PD_BIT] = pd_bit;
    return word;
  endfunction

  wire prescaler_assign = prescale_config[`WDS_PSA_BIT];
  wire [2:0] ratio = prescale_config[`WDS_RATIO_MSB:0];
  wire in_reset = (state == WDS_HOLD);
  wire wdt_clear = kick_instruction_in | sleep_instruction_in | in_reset;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      prescale_config <= `WDS_PRESCALE_RESET;
    end else if (in_reset) begin
      prescale_config <= `WDS_PRESCALE_RESET;
    end else if (wr_in && addr_in == `WDS_ADDR_PRESCALE) begin
      prescale_config <= wdata_in[5:0];
    end
  end

  // ---------------------------------------------------------------
  // watchdog counter and postscaler
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wdt_count <= 32'h0;
      post_count <= 7'h0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (!fuse_on) begin
        wdt_count <= 32'h0;
        post_count <= 7'h0;
      end else if (wdt_clear) begin
        wdt_count <= 32'h0;
        if (prescaler_assign) begin
          post_count <= 7'h0;
        end
      end else if (osc_edge) begin
        if (wdt_count >= 32'(TIMEOUT_CYC - 1)) begin
          wdt_count <= 32'h0;
          if (!prescaler_assign || post_count == ratio_mask(ratio)) begin
            post_count <= 7'h0;
            expire <= 1'b1;
          end else begin
            post_count <= post_count + 7'h1;
          end
        end else begin
          wdt_count <= wdt_count + 32'h1;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // sleep and reset sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      WDS_RUN: begin
        if (expire || master_clear_pin_low) begin
          next_state = WDS_HOLD;
        end else if (sleep_instruction_in) begin
          next_state = WDS_SLEEP;
        end
      end
      WDS_SLEEP: begin
        if (expire || master_clear_pin_low) begin
          next_state = WDS_HOLD;
        end
      end
      WDS_HOLD: begin
        if (!master_clear_pin_low && hold_count >= 32'(HOLD_CYC - 1)) begin
          next_state = WDS_RUN;
        end
      end
      default: begin
        next_state = WDS_HOLD;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state <= WDS_HOLD;
      hold_count <= 32'h0;
    end else begin
      state <= next_state;
      if (next_state != WDS_HOLD || master_clear_pin_low || (state != WDS_HOLD)) begin
        hold_count <= 32'h0;
      end else begin
        hold_count <= hold_count + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // reset cause flags
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (expire) begin
      timeout_flag <= 1'b0;
    end else if (in_reset) begin
      timeout_flag <= timeout_flag;
    end else if (sleep_instruction_in) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (kick_instruction_in) begin
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // id words and register reads
  // ---------------------------------------------------------------
  wire [1:0] id_idx = 2'(addr_in - `WDS_ADDR_ID0);
  // upper bound keeps higher addresses from aliasing onto the id words
  wire id_hit = (addr_in >= `WDS_ADDR_ID0) && (addr_in < 4'(`WDS_ADDR_ID0 + `WDS_ID_COUNT))
    && prog_mode;

  always_ff @(posedge clk_in) begin
    if (wr_in && id_hit) begin
      id_mem[id_idx] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 12'h000;
    end else if (rd_in) begin
      if (addr_in == `WDS_ADDR_STATUS) begin
        rdata_out <= status_word(timeout_flag, powerdown_flag);
      end else if (id_hit && addr_in < 4'(`WDS_ADDR_ID0 + `WDS_ID_COUNT)) begin
        rdata_out <= id_mem[id_idx];
      end else begin
        rdata_out <= 12'h000;
      end
    end else begin
      rdata_out <= 12'h000;
    end
  end

  // ---------------------------------------------------------------
  // registered outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cpu_reset_out <= 1'b1;
      osc_driver_en_out <= 1'b1;
      pin_hold_out <= 1'b0;
      master_clear_oe_out <= 1'b0;
      verify_read_en_out <= 1'b0;
      timeout_flag_out <= 1'b1;
      powerdown_flag_out <= 1'b1;
    end else begin
      cpu_reset_out <= (next_state == WDS_HOLD);
      osc_driver_en_out <= (next_state != WDS_SLEEP);
      pin_hold_out <= (next_state == WDS_SLEEP);
      master_clear_oe_out <= 1'b0;
      verify_read_en_out <= prog_mode & unprotected;
      timeout_flag_out <= timeout_flag;
      powerdown_flag_out <= powerdown_flag;
    end
  end

  // ---------------------------------------------------------------
  // reset hold length monitor
  // ---------------------------------------------------------------
  // counts cycles spent with the core held in reset
  logic [31:0] reset_run;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      reset_run <= 32'h0;
    end else if (cpu_reset_out) begin
      reset_run <= reset_run + 32'h1;
    end else begin
      reset_run <= 32'h0;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  fuse_blocks_expiry_a: assert property (!fuse_on |=> !expire)
    else $error("expiry while fuse off");
  expiry_clears_to_a: assert property (expire |=> !timeout_flag)
    else $error("timeout flag not cleared");
  expiry_resets_a: assert property (expire |=> ##1 cpu_reset_out)
    else $error("no reset after expiry");
  sleep_flags_a: assert property (sleep_instruction_in && !expire && !in_reset
    |=> timeout_flag && !powerdown_flag)
    else $error("sleep flags wrong");
  kick_clears_a: assert property (kick_instruction_in && fuse_on
    |=> wdt_count == 32'h0)
    else $error("kick did not clear");
  pin_never_driven_a: assert property (!master_clear_oe_out)
    else $error("reset pin driven");
  pd_kept_expiry_a: assert property (expire |=> $stable(powerdown_flag))
    else $error("powerdown changed on expiry");
  sleep_osc_off_a: assert property (state == WDS_SLEEP |-> !osc_driver_en_out)
    else $error("oscillator on in sleep");
  wake_clears_a: assert property (in_reset |=> wdt_count == 32'h0)
    else $error("counter not cleared on wake");

  // ---------------------------------------------------------------
  // checks: sleep, wake, pins, flags, prescale config, verify gate and counters
  // ---------------------------------------------------------------
  pin_keeps_flags_a: assert property (master_clear_pin_low && !expire && !sleep_instruction_in
    && !kick_instruction_in |=> $stable(timeout_flag) && $stable(powerdown_flag))
    else $error("pin reset changed flags");
  kick_flags_a: assert property (kick_instruction_in && !sleep_instruction_in
    && !expire && !in_reset |=> timeout_flag && powerdown_flag)
    else $error("kick flags wrong");
  sleep_stays_a: assert property (state == WDS_SLEEP && !expire && !master_clear_pin_low
    |=> state == WDS_SLEEP)
    else $error("left sleep without cause");
  wake_resets_a: assert property (state == WDS_SLEEP && (expire || master_clear_pin_low)
    |=> cpu_reset_out && !pin_hold_out)
    else $error("wake without reset");
  config_reset_a: assert property (in_reset
    |=> prescale_config == `WDS_PRESCALE_RESET)
    else $error("prescale config not reset");
  verify_gate_a: assert property (!unprotected
    |=> !verify_read_en_out)
    else $error("verify open while protected");
  hold_length_a: assert property ($fell(cpu_reset_out)
    |-> reset_run >= 32'(HOLD_CYC))
    else $error("reset hold too short");

  sleep_clears_a: assert property (sleep_instruction_in && fuse_on
    |=> wdt_count == 32'h0)
    else $error("sleep did not clear");
  pin_hold_a: assert property (state == WDS_SLEEP
    |-> pin_hold_out)
    else $error("pins not held in sleep");
  kick_post_a: assert property (kick_instruction_in && fuse_on && prescaler_assign
    |=> post_count == 7'h0)
    else $error("kick left prescaler");
  fuse_off_count_a: assert property (!fuse_on
    |=> wdt_count == 32'h0 && post_count == 7'h0)
    else $error("counter runs with fuse off");
  expiry_holds_a: assert property (expire
    |=> in_reset)
    else $error("expiry did not enter reset");

  // ---------------------------------------------------------------
  // cover points
  // ---------------------------------------------------------------
  cover_sleep_c: cover property (state == WDS_SLEEP ##1 state == WDS_HOLD);
  cover_expire_c: cover property (expire && state == WDS_RUN);
  cover_kick_c: cover property (kick_instruction_in);
  cover_pin_wake_c: cover property (state == WDS_SLEEP && master_clear_pin_low);
  cover_prescaled_c: cover property (expire && prescaler_assign);
endmodule // wds_watchdog
`default_nettype wire

/* sim/wds_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module wds_core_model (
  input wire logic clk_in,
  input wire logic cpu_reset_in,
  output logic kick_out,
  output logic sleep_out
);
  initial begin
    kick_out = 1'b0;
    sleep_out = 1'b0;
  end
  // one-cycle instruction pulse, never while the core is held in reset
  task automatic issue(input logic is_sleep);
    @(posedge clk_in);
    while (cpu_reset_in !== 1'b0) @(posedge clk_in);
    if (is_sleep) sleep_out <= 1'b1;
    else kick_out <= 1'b1;
    @(posedge clk_in);
    kick_out <= 1'b0;
    sleep_out <= 1'b0;
  endtask
endmodule // wds_core_model
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "wds_consts.svh"
module tb_top;
  logic clk_in = 0, rst_in = 1, tick = 0, master_clear_pin_n = 1, fuse = 1, cp_n = 1, prog = 0;
  logic wr = 0, rd = 0, kick, sleep, cpu_rst, osc_en, hold, mc_oe, ver_en, to_f, pd_f;
  logic [3:0] addr = 4'h0;
  logic [11:0] wdata = 12'h000, rdata, got;
  int mismatches = 0, checks_done = 0, cycles = 0;
  always #50 clk_in = ~clk_in;
  // watchdog oscillator, unrelated in phase to the main clock
  always #213 tick = ~tick;
  wds_core_model core (.clk_in(clk_in), .cpu_reset_in(cpu_rst), .kick_out(kick),
    .sleep_out(sleep));
  wds_watchdog #(.TIMEOUT_CYC(8), .HOLD_CYC(6)) dut (.clk_in(clk_in), .rst_in(rst_in),
    .wdt_osc_tick_in(tick), .master_clear_n_in(master_clear_pin_n), .watchdog_enable_fuse_in(fuse),
    .code_protect_n_in(cp_n), .program_mode_in(prog), .kick_instruction_in(kick),
    .sleep_instruction_in(sleep), .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd),
    .rdata_out(rdata), .cpu_reset_out(cpu_rst), .osc_driver_en_out(osc_en),
    .pin_hold_out(hold), .master_clear_oe_out(mc_oe), .verify_read_en_out(ver_en),
    .timeout_flag_out(to_f), .powerdown_flag_out(pd_f));
  task automatic report_and_stop;
    $display("mismatches=%0d checks_done=%0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [11:0] g, input logic [11:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [11:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1 got = rdata;
  endtask
  task automatic wait_rst(input logic lvl, input int n);
    for (int i = 0; i < n && cpu_rst !== lvl; i++) begin
      @(posedge clk_in);
      #1;
    end
    chk({11'h0, cpu_rst}, {11'h0, lvl}, "reset level");
  endtask
  task automatic no_rst(input int n);
    repeat (n) begin
      @(posedge clk_in);
      #1;
      if (cpu_rst !== 1'b0) break;
    end
    chk({11'h0, cpu_rst}, 12'h000, "unexpected reset");
  endtask
  // flag outputs are registered copies, one cycle behind the flags
  task automatic flags(input logic t, input logic p);
    @(posedge clk_in);
    #1 chk({10'h0, to_f, pd_f}, {10'h0, t, p}, "flags");
  endtask
  task automatic pin_pulse;
    @(posedge clk_in);
    master_clear_pin_n <= 1'b0;
    cyc(4);
    master_clear_pin_n <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_powerup;
    wait_rst(1'b0, 20);
    flags(1'b1, 1'b1);
    reg_rd(`WDS_ADDR_STATUS);
    chk({10'h0, got[4:3]}, 12'h003, "status");
  endtask
  task automatic t_fuse_off;
    reg_wr(`WDS_ADDR_PRESCALE, 12'h037);
    fuse <= 1'b0;
    no_rst(200);
    core.issue(1'b0);
    fuse <= 1'b1;
  endtask
  task automatic t_kick;
    repeat (12) begin
      core.issue(1'b0);
      no_rst(14);
    end
    flags(1'b1, 1'b1);
  endtask
  task automatic t_wdt_run;
    wait_rst(1'b1, 100);
    flags(1'b0, 1'b1);
    chk({11'h0, mc_oe}, 12'h000, "pin driven");
    wait_rst(1'b0, 20);
    no_rst(300);
  endtask
  task automatic t_sleep_wdt;
    core.issue(1'b0);
    reg_wr(`WDS_ADDR_PRESCALE, 12'h037);
    core.issue(1'b1);
    #1 chk({10'h0, osc_en, hold}, 12'h001, "sleep outputs");
    flags(1'b1, 1'b0);
    no_rst(20);
    wait_rst(1'b1, 100);
    flags(1'b0, 1'b0);
    wait_rst(1'b0, 20);
    chk({11'h0, osc_en}, 12'h001, "awake");
  endtask
  task automatic t_pin_wake;
    core.issue(1'b1);
    pin_pulse;
    wait_rst(1'b0, 30);
    flags(1'b1, 1'b0);
    pin_pulse;
    wait_rst(1'b0, 30);
    flags(1'b1, 1'b0);
  endtask
  task automatic t_por;
    @(posedge clk_in);
    rst_in <= 1'b1;
    cyc(5);
    rst_in <= 1'b0;
    #1 chk({11'h0, cpu_rst}, 12'h001, "held after reset");
    wait_rst(1'b0, 20);
    flags(1'b1, 1'b1);
  endtask
  task automatic t_prescale;
    core.issue(1'b0);
    reg_wr(`WDS_ADDR_PRESCALE, 12'h039);
    no_rst(50);
    wait_rst(1'b1, 60);
    flags(1'b0, 1'b1);
    wait_rst(1'b0, 20);
  endtask
  task automatic t_prog;
    @(posedge clk_in);
    prog <= 1'b1;
    cyc(2);
    reg_wr(`WDS_ADDR_ID0, 12'hFF5);
    reg_rd(`WDS_ADDR_ID0);
    chk(got, 12'hFF5, "id word");
    chk({11'h0, ver_en}, 12'h001, "verify open");
    @(posedge clk_in);
    cp_n <= 1'b0;
    cyc(3);
    #1 chk({11'h0, ver_en}, 12'h000, "verify shut");
    @(posedge clk_in);
    prog <= 1'b0;
    cyc(2);
    reg_rd(`WDS_ADDR_ID0);
    chk(got, 12'h000, "id hidden");
    reg_rd(4'hF);
    chk(got, 12'h000, "unmapped");
  endtask
  initial begin
    cyc(5);
    rst_in <= 1'b0;
    t_powerup;
    t_fuse_off;
    t_kick;
    t_wdt_run;
    t_sleep_wdt;
    t_pin_wake;
    t_por;
    t_prescale;
    t_prog;
    report_and_stop;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop;
    end
  end
endmodule // tb_top
`default_nettype wire
